// ==== hdl/atc_pkg.sv ====
// constants and types for the 8-bit timer with two compare channels
// Function
// - zero counter value is bottom, flagged
// - all-ones counter value is max, flagged
// - top is max or compare A by mode
// - interrupt flags in one register, individually masked
// - timer tick from core clock or oscillator
// - clock select zero stops the counter
// - software reads and writes counter anytime
// - software counter write beats hardware update
// - three-bit mode picks clear, up or down
// - both compare registers compared with counter
// - match flag set one tick after match
// - enabled flag requests interrupt, cleared on service
// - writing one clears a flag
// - compare buffering only in pwm modes
// - buffered value loads at top or bottom
// - software compare writes go to buffer when buffered; reads see the active register
// - force strobe forces match in non-pwm modes
// - forced match drives pin only, no flag
// - overflow flag set per mode, interrupts
// - output from match, mode and action field
// - counter write blocks match next tick
// - action field zero leaves output alone
// - mode zero counts up, overflow at wrap
// - mode two clears counter on compare A
package atc_pkg;
	localparam int          ATC_W        = 8;
	localparam logic [7:0]  ATC_BOTTOM   = 8'h00;
	localparam logic [7:0]  ATC_MAX      = 8'hFF;
	localparam logic [7:0]  ATC_ONE      = 8'h01;
	localparam logic [2:0]  ATC_CS_STOP  = 3'h0;
	localparam logic [2:0]  ATC_CS_DIRECT= 3'h1;
	localparam logic [2:0]  ATC_CS_EXT_F = 3'h6;
	localparam logic [2:0]  ATC_CS_EXT_R = 3'h7;
	localparam logic [1:0]  ATC_ACT_NONE = 2'h0;
	localparam logic [1:0]  ATC_ACT_TOG  = 2'h1;
	localparam logic [1:0]  ATC_ACT_CLR  = 2'h2;
	localparam logic [1:0]  ATC_ACT_SET  = 2'h3;
	localparam int          ATC_FLAG_OVF = 0;
	localparam int          ATC_FLAG_MA  = 1;
	localparam int          ATC_FLAG_MB  = 2;
	localparam logic [2:0]  ATC_FLAG_RST = 3'h0;
	localparam int          ATC_PRE_W    = 10;
	localparam logic [9:0]  ATC_PRE_ONE  = 10'h001;
	typedef enum logic [2:0] {
		ATC_WM_NORMAL  = 3'b000,
		ATC_WM_PC_MAX  = 3'b001,
		ATC_WM_CTC     = 3'b010,
		ATC_WM_FAST    = 3'b011,
		ATC_WM_RSV4    = 3'b100,
		ATC_WM_PC_OCRA = 3'b101,
		ATC_WM_RSV6    = 3'b110,
		ATC_WM_FAST_A  = 3'b111
	} atc_mode_e;
endpackage

// ==== hdl/atc_timer.sv ====
// 8-bit timer/counter with two compare channels, plain-port control
module atc_timer
	import atc_pkg::*;
#(
	parameter int W = ATC_W
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         reset,
	// clock source control
	input  wire logic         async_clock_select,
	input  wire logic         osc_pin_in,
	input  wire logic [2:0]   clock_select_field,
	// mode control
	input  wire logic         waveform_mode_bit0,
	input  wire logic         waveform_mode_bit1,
	input  wire logic         waveform_mode_bit2,
	input  wire logic [1:0]   output_action_a,
	input  wire logic [1:0]   output_action_b,
	input  wire logic         force_match_a,
	input  wire logic         force_match_b,
	// counter access
	input  wire logic         count_wr,
	input  wire logic [W-1:0] count_wdata,
	// compare register access
	input  wire logic         compare_a_wr,
	input  wire logic         compare_b_wr,
	input  wire logic [W-1:0] compare_wdata,
	// flags and masks
	input  wire logic [2:0]   flag_clear,
	input  wire logic [2:0]   flag_serviced,
	input  wire logic [2:0]   timer_mask_reg,
	// status
	output logic [W-1:0]      count_value_reg,
	output logic [W-1:0]      compare_a_reg,
	output logic [W-1:0]      compare_b_reg,
	output logic [2:0]        timer_flag_reg,
	output logic [2:0]        irq_req,
	output logic              at_bottom,
	output logic              at_max,
	// compare outputs
	output logic              compare_out_a,
	output logic              compare_out_b
);
	atc_mode_e     mode;
	logic          pwm;
	logic          tick;
	logic [9:0]    pre_r;
	logic          osc_r;
	logic          osc_d_r;
	logic          ext_r;
	logic          ext_d_r;
	logic [W-1:0]  top;
	logic          down_r;
	logic          block_r;
	logic [W-1:0]  buf_a_r;
	logic [W-1:0]  buf_b_r;
	logic          match_a;
	logic          match_b;
	logic          clr_cnt;
	logic          up_now;
	logic          ovf_ev;
	logic          load_ev;
	logic [W-1:0]  cnt_nxt;
	logic          phase_corr;

	// a tap fires when this many low prescaler bits are all ones
	localparam int TAP_8    = 3;
	localparam int TAP_32   = 5;
	localparam int TAP_64   = 6;
	localparam int TAP_128  = 7;
	localparam int TAP_256  = 8;
	localparam int TAP_1024 = 10;

	assign mode       = atc_mode_e'({waveform_mode_bit2, waveform_mode_bit1,
		waveform_mode_bit0});
	assign pwm        = (mode != ATC_WM_NORMAL) && (mode != ATC_WM_CTC);
	assign phase_corr = (mode == ATC_WM_PC_MAX) || (mode == ATC_WM_PC_OCRA);

	// free-running prescaler; every slower rate is a tap of it
	always_ff @(posedge ref_clk) begin
		if (reset)
			pre_r <= '0;
		else
			pre_r <= pre_r + ATC_PRE_ONE;
	end

	// oscillator pin: two-flop synchroniser, then an edge-detect pair
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			osc_r   <= 1'b0;
			osc_d_r <= 1'b0;
			ext_r   <= 1'b0;
			ext_d_r <= 1'b0;
		end else begin
			osc_r   <= osc_pin_in;
			osc_d_r <= osc_r;
			ext_r   <= osc_d_r;
			ext_d_r <= ext_r;
		end
	end

	function automatic logic pre_tap(input logic [2:0] cs, input logic [9:0] p);
		unique case (cs)
			ATC_CS_DIRECT: pre_tap = 1'b1;
			3'h2:          pre_tap = &p[TAP_8-1:0];
			3'h3:          pre_tap = &p[TAP_32-1:0];
			3'h4:          pre_tap = &p[TAP_64-1:0];
			3'h5:          pre_tap = &p[TAP_128-1:0];
			3'h6:          pre_tap = &p[TAP_256-1:0];
			3'h7:          pre_tap = &p[TAP_1024-1:0];
			default: pre_tap = 1'b0;
		endcase
	endfunction

	// the oscillator ticks once per rising edge; the prescaler taps are not applied to it
	always_comb begin
		if (clock_select_field == ATC_CS_STOP)
			tick = 1'b0;
		else if (async_clock_select)
			tick = ext_r & ~ext_d_r;
		else
			tick = pre_tap(clock_select_field, pre_r);
	end

	// top is compare A in ctc and in the two top-from-A pwm modes
	assign top     = (mode == ATC_WM_CTC || mode == ATC_WM_PC_OCRA || mode == ATC_WM_FAST_A)
		? compare_a_reg : ATC_MAX;
	assign match_a = (count_value_reg == compare_a_reg) && !block_r;
	assign match_b = (count_value_reg == compare_b_reg) && !block_r;
	// normal mode ignores this: its top is max and the plain increment wraps
	assign clr_cnt = (!phase_corr && count_value_reg == top) || (mode == ATC_WM_CTC && match_a);
	assign up_now  = !phase_corr || !down_r;

	// next count: clear at top, otherwise up or down
	always_comb begin
		if (clr_cnt && mode != ATC_WM_NORMAL)
			cnt_nxt = ATC_BOTTOM;
		else if (up_now)
			cnt_nxt = count_value_reg + ATC_ONE;
		else
			cnt_nxt = count_value_reg - ATC_ONE;
	end

	// overflow: wrap to bottom in up modes, reaching bottom in phase correct
	assign ovf_ev  = tick && (phase_corr ? (count_value_reg == ATC_ONE && down_r)
		: (cnt_nxt == ATC_BOTTOM)) && !count_wr;
	assign load_ev = tick && (phase_corr ? (count_value_reg == top)
		: (cnt_nxt == ATC_BOTTOM));

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			count_value_reg <= ATC_BOTTOM;
		end else if (count_wr) begin
			count_value_reg <= count_wdata;
		end else if (tick) begin
			count_value_reg <= cnt_nxt;
		end
	end

	// direction only matters in phase correct modes; turns at top and just above bottom
	always_ff @(posedge ref_clk) begin
		if (reset)
			down_r <= 1'b0;
		else if (!phase_corr)
			down_r <= 1'b0;
		else if (tick && count_value_reg == top)
			down_r <= 1'b1;
		else if (tick && count_value_reg == ATC_ONE)
			down_r <= 1'b0;
	end

	// a counter write blocks matches until the next tick has passed
	always_ff @(posedge ref_clk) begin
		if (reset)
			block_r <= 1'b0;
		else if (count_wr)
			block_r <= 1'b1;
		else if (tick)
			block_r <= 1'b0;
	end

	// compare A: written directly outside pwm, copied from its buffer in pwm
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			compare_a_reg <= ATC_BOTTOM;
			buf_a_r       <= ATC_BOTTOM;
		end else begin
			if (compare_a_wr)
				buf_a_r <= compare_wdata;
			if (!pwm && compare_a_wr)
				compare_a_reg <= compare_wdata;
			else if (pwm && load_ev)
				compare_a_reg <= compare_a_wr ? compare_wdata : buf_a_r;
		end
	end

	// compare B: same scheme; a write on the load cycle goes straight through
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			compare_b_reg <= ATC_BOTTOM;
			buf_b_r       <= ATC_BOTTOM;
		end else begin
			if (compare_b_wr)
				buf_b_r <= compare_wdata;
			if (!pwm && compare_b_wr)
				compare_b_reg <= compare_wdata;
			else if (pwm && load_ev)
				compare_b_reg <= compare_b_wr ? compare_wdata : buf_b_r;
		end
	end

	// flags: hardware set beats a software or service clear
	logic [2:0] set_ev;
	assign set_ev = {tick && match_b, tick && match_a, ovf_ev};

	always_ff @(posedge ref_clk) begin
		if (reset)
			timer_flag_reg <= ATC_FLAG_RST;
		else
			timer_flag_reg <= set_ev
				| (timer_flag_reg & ~(flag_clear | flag_serviced));
	end

	// registered, so requests trail their flags by one cycle
	always_ff @(posedge ref_clk) begin
		if (reset)
			irq_req <= ATC_FLAG_RST;
		else
			irq_req <= timer_flag_reg & timer_mask_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			at_bottom <= 1'b0;
		else
			at_bottom <= (count_value_reg == ATC_BOTTOM);
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			at_max <= 1'b0;
		else
			at_max <= (count_value_reg == ATC_MAX);
	end

	// output level for one channel; force only counts outside pwm modes
	function automatic logic wave_next(input logic cur, input logic [1:0] act,
		input logic hit, input logic frc, input logic is_pwm, input logic dn,
		input logic bot);
		logic lvl;
		lvl = cur;
		if (act == ATC_ACT_NONE) begin
			lvl = cur;
		end else if (!is_pwm) begin
			if (hit || frc) begin
				unique case (act)
					ATC_ACT_TOG: lvl = ~cur;
					ATC_ACT_CLR: lvl = 1'b0;
					ATC_ACT_SET: lvl = 1'b1;
					default:     lvl = cur;
				endcase
			end
		end else if (act[1]) begin
			if (hit)
				// non-inverting clears on an up-count match, sets on a down-count one
				lvl = act[0] ^ dn;
			else if (bot)
				lvl = ~act[0];
		end
		wave_next = lvl;
	endfunction

	// bottom is a waveform event in every pwm mode that is not phase correct
	logic bot_tick;
	assign bot_tick = tick && !phase_corr && cnt_nxt == ATC_BOTTOM;

	// pin state survives mode changes; only matches, bottom and force move it
	always_ff @(posedge ref_clk) begin
		if (reset)
			compare_out_a <= 1'b0;
		else
			compare_out_a <= wave_next(compare_out_a, output_action_a, tick && match_a,
				force_match_a, pwm, down_r, bot_tick);
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			compare_out_b <= 1'b0;
		else
			compare_out_b <= wave_next(compare_out_b, output_action_b, tick && match_b,
				force_match_b, pwm, down_r, bot_tick);
	end
endmodule

// ==== tb/atc_osc_model.sv ====
// external oscillator model feeding the timer's oscillator pin
module atc_osc_model (
	// control
	input  wire logic       go,
	input  wire logic [3:0] pulses,
	// pin
	output logic            osc_pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// idles low between bursts so no stray edge reaches the timer
	initial begin
		osc_pin_in = 1'b0;
		forever begin
			@(posedge go);
			repeat (pulses) begin
				#36 osc_pin_in = 1'b1;
				#36 osc_pin_in = 1'b0;
			end
		end
	end
endmodule

// ==== tb/atc_timer_asserts.sv ====
// concurrent checks on the timer's ports
module atc_timer_asserts
	import atc_pkg::*;
#(
	parameter int W = ATC_W
) (
	// control
	input wire logic         ref_clk,
	input wire logic         reset,
	input wire logic         async_clock_select,
	input wire logic [2:0]   clock_select_field,
	input wire logic [1:0]   output_action_a,
	input wire logic         count_wr,
	input wire logic [W-1:0] count_wdata,
	input wire logic [2:0]   flag_clear,
	input wire logic [2:0]   timer_mask_reg,
	// status
	input wire logic [W-1:0] count_value_reg,
	input wire logic [W-1:0] compare_a_reg,
	input wire logic [W-1:0] compare_b_reg,
	input wire logic [2:0]   timer_flag_reg,
	input wire logic [2:0]   irq_req,
	input wire logic         at_bottom,
	input wire logic         at_max,
	input wire logic         compare_out_a
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_reset_zero: assert property (disable iff (1'b0) reset |=> count_value_reg == '0 &&
		compare_a_reg == '0 && compare_b_reg == '0 && timer_flag_reg == ATC_FLAG_RST)
		else $error("state not cleared by reset");
	a_stop_hold: assert property ((clock_select_field == ATC_CS_STOP &&
		!async_clock_select && !count_wr)[*4] |=> $stable(count_value_reg))
		else $error("counter moved while stopped");
	a_cpu_write: assert property (count_wr |=> count_value_reg == $past(count_wdata))
		else $error("counter write lost");
	a_bottom_seen: assert property (!$past(reset) |->
		at_bottom == ($past(count_value_reg) == ATC_BOTTOM)) else $error("bottom wrong");
	a_max_seen: assert property (!$past(reset) |->
		at_max == ($past(count_value_reg) == ATC_MAX)) else $error("max wrong");
	a_irq_mask: assert property (!$past(reset) |->
		irq_req == $past(timer_flag_reg & timer_mask_reg)) else $error("irq mask wrong");
	a_flag_clear: assert property ((flag_clear == 3'h7 &&
		clock_select_field == ATC_CS_STOP && !async_clock_select)[*4] |=> timer_flag_reg == 3'h0)
		else $error("flags not cleared");
	a_no_action: assert property (!$past(reset) &&
		$past(output_action_a) == ATC_ACT_NONE |-> $stable(compare_out_a))
		else $error("output moved with no action");
	c_match_a: cover property ($rose(timer_flag_reg[ATC_FLAG_MA]));
	c_irq_ovf: cover property ($rose(irq_req[ATC_FLAG_OVF]));
	c_toggle: cover property ($changed(compare_out_a));
endmodule
bind atc_timer atc_timer_asserts #(.W(W)) u_chk (.*);

// ==== tb/test_atc_timer.sv ====
// self-checking bench for the timer with two compare channels
module test_atc_timer
	import atc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [7:0] val; logic bot; logic mx;} atc_row_s;
	logic       ref_clk, reset, async_clock_select, force_match_a, force_match_b;
	logic       count_wr, compare_a_wr, compare_b_wr, go, prev_out;
	logic       at_bottom, at_max, compare_out_a, compare_out_b, osc_pin_in;
	logic [2:0] clock_select_field, flag_clear, flag_serviced, timer_mask_reg, mode;
	logic [2:0] timer_flag_reg, irq_req;
	logic [1:0] output_action_a, output_action_b;
	logic [7:0] count_wdata, compare_wdata, count_value_reg, compare_a_reg, compare_b_reg;
	int         err_count, n_tests, i;
	atc_row_s   rows [3] = '{'{8'h00, 1'b1, 1'b0}, '{8'hff, 1'b0, 1'b1}, '{8'h05, 1'b0, 1'b0}};
	atc_timer uut (.ref_clk(ref_clk), .reset(reset), .async_clock_select(async_clock_select),
		.osc_pin_in(osc_pin_in), .clock_select_field(clock_select_field),
		.waveform_mode_bit0(mode[0]), .waveform_mode_bit1(mode[1]), .waveform_mode_bit2(mode[2]),
		.output_action_a(output_action_a), .output_action_b(output_action_b),
		.force_match_a(force_match_a), .force_match_b(force_match_b), .count_wr(count_wr),
		.count_wdata(count_wdata), .compare_a_wr(compare_a_wr), .compare_b_wr(compare_b_wr),
		.compare_wdata(compare_wdata), .flag_clear(flag_clear), .flag_serviced(flag_serviced),
		.timer_mask_reg(timer_mask_reg), .count_value_reg(count_value_reg),
		.compare_a_reg(compare_a_reg), .compare_b_reg(compare_b_reg),
		.timer_flag_reg(timer_flag_reg), .irq_req(irq_req), .at_bottom(at_bottom),
		.at_max(at_max), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b));
	atc_osc_model u_osc (.go(go), .pulses(4'h4), .osc_pin_in(osc_pin_in));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic wr_cnt(input logic [7:0] v);
		count_wdata = v;
		count_wr = 1'b1;
		cyc(1);
		count_wr = 1'b0;
	endtask
	task automatic set_cmp(input logic a, input logic [7:0] v);
		compare_wdata = v;
		{compare_a_wr, compare_b_wr} = {a, !a};
		cyc(1);
		{compare_a_wr, compare_b_wr} = 2'b00;
	endtask
	// held four cycles so no late tick can re-set a flag behind the clear
	task automatic clr();
		flag_clear = 3'h7;
		cyc(4);
		flag_clear = 3'h0;
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// whole run is about 120 cycles; this span is far beyond it
	initial begin
		#100us;
		err_count++;
		end_of_test();
	end
	initial begin
		{reset, async_clock_select, force_match_a, force_match_b, go} = 5'h10;
		{count_wr, compare_a_wr, compare_b_wr, count_wdata, compare_wdata} = '0;
		{clock_select_field, flag_clear, flag_serviced, timer_mask_reg, mode} = '0;
		{output_action_a, output_action_b} = '0;
		cyc(4);
		reset = 1'b0;
		check(count_value_reg | compare_a_reg | compare_b_reg, 8'h00, "reset regs");
		check(timer_flag_reg, 8'h00, "reset flags");
		$display("reset test done");
		foreach (rows[k]) begin
			wr_cnt(rows[k].val);
			cyc(3);
			check(count_value_reg, rows[k].val, "stopped count");
			check(at_bottom, rows[k].bot, "bottom");
			check(at_max, rows[k].mx, "max");
		end
		$display("row test done");
		timer_mask_reg = 3'h7;
		wr_cnt(8'hfe);
		clr();
		clock_select_field = ATC_CS_DIRECT;
		for (i = 0; i < 20 && count_value_reg !== 8'h00; i++) cyc(1);
		check(timer_flag_reg[ATC_FLAG_OVF], 1'b1, "overflow flag");
		cyc(1);
		clock_select_field = ATC_CS_STOP;
		check(irq_req[ATC_FLAG_OVF], 1'b1, "overflow irq");
		flag_serviced = 3'h1;
		cyc(1);
		flag_serviced = 3'h0;
		check(timer_flag_reg[ATC_FLAG_OVF], 1'b0, "serviced flag");
		$display("overflow test done");
		clr();
		mode = ATC_WM_CTC;
		set_cmp(1'b1, 8'h03);
		check(compare_a_reg, 8'h03, "compare a direct");
		wr_cnt(8'h00);
		output_action_a = ATC_ACT_TOG;
		prev_out = compare_out_a;
		clock_select_field = ATC_CS_DIRECT;
		for (i = 0; i < 20 && timer_flag_reg[ATC_FLAG_MA] !== 1'b1; i++) cyc(1);
		check(timer_flag_reg[ATC_FLAG_MA], 1'b1, "match a flag");
		check(compare_out_a, !prev_out, "toggle on match");
		output_action_a = ATC_ACT_NONE;
		for (i = 0; i < 12; i++) begin
			cyc(1);
			check(count_value_reg > 8'h03, 1'b0, "ctc wrap");
		end
		clock_select_field = ATC_CS_STOP;
		$display("ctc test done");
		set_cmp(1'b0, 8'h09);
		check(compare_b_reg, 8'h09, "compare b direct");
		wr_cnt(8'h09);
		clr();
		clock_select_field = ATC_CS_DIRECT;
		cyc(3);
		clock_select_field = ATC_CS_STOP;
		check(timer_flag_reg[ATC_FLAG_MB], 1'b0, "blocked match");
		$display("block test done");
		mode = ATC_WM_NORMAL;
		wr_cnt(8'h20);
		for (i = 3; i >= 2; i--) begin
			output_action_b = 2'(i);
			force_match_b = 1'b1;
			cyc(1);
			force_match_b = 1'b0;
			cyc(1);
			check(compare_out_b, 8'(i == 3), "forced pin");
			check(timer_flag_reg[ATC_FLAG_MB], 1'b0, "forced flag");
			check(count_value_reg, 8'h20, "forced count");
		end
		$display("force test done");
		async_clock_select = 1'b1;
		clock_select_field = ATC_CS_DIRECT;
		cyc(4);
		wr_cnt(8'h10);
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		cyc(40);
		check(count_value_reg, 8'h14, "oscillator ticks");
		async_clock_select = 1'b0;
		clock_select_field = ATC_CS_STOP;
		$display("oscillator test done");
		mode = ATC_WM_FAST;
		set_cmp(1'b1, 8'h40);
		check(compare_a_reg, 8'h03, "buffered write held");
		wr_cnt(8'hfe);
		clock_select_field = ATC_CS_DIRECT;
		cyc(1);
		check(compare_a_reg, 8'h03, "no load before wrap");
		cyc(1);
		check(compare_a_reg, 8'h40, "load at wrap");
		check(compare_out_b, 8'h01, "pwm set at bottom");
		cyc(10);
		check(compare_out_b, 8'h00, "pwm clear on match");
		check(timer_flag_reg[ATC_FLAG_MB], 1'b1, "pwm match flag");
		clock_select_field = ATC_CS_STOP;
		$display("pwm test done");
		reset = 1'b1;
		cyc(1);
		reset = 1'b0;
		check(count_value_reg | compare_a_reg | compare_b_reg, 8'h00, "late reset regs");
		check(timer_flag_reg, 8'h00, "late reset flags");
		$display("mid-run reset test done");
		end_of_test();
	end
endmodule
